// ===== rtl/hbi_pkg.sv
// shared constants and types for the host bus pin interface
package hbi_pkg;
  typedef enum logic [1:0] {
    HBI_LOCAL,
    HBI_CARD,
    HBI_PROC
  } hbi_mode_e;

  localparam int         CLK_PERIOD_NS   = 4;
  localparam int         RESET_MIN_NS    = 100;
  localparam int         RESET_MIN_CYC   =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] RESET_CNT_MAX   = 5'(RESET_MIN_CYC);

  localparam logic [3:0]  BASE_LOW_NIBBLE = 4'h0;
  localparam logic [15:0] CARD_OPT_OFS    = 16'h0000;
  localparam logic [15:0] CARD_STAT_OFS   = 16'h0002;
  localparam int          CARD_FUNC_BIT   = 0;
  localparam logic [7:0]  CARD_OPT_RST    = 8'h00;
  localparam logic [7:0]  CARD_STAT_RST   = 8'h00;
  localparam logic [15:0] DATA_PULLUP     = 16'hFFFF;

  // host controller register map, byte addresses
  localparam logic [7:0] HR_CTRL     = 8'h00;
  localparam logic [7:0] HR_ADDR     = 8'h04;
  localparam logic [7:0] HR_WDATA    = 8'h08;
  localparam logic [7:0] HR_CMD      = 8'h0C;
  localparam logic [7:0] HR_RDATA    = 8'h10;
  localparam logic [7:0] HR_STATUS   = 8'h14;
  localparam logic [7:0] HR_INT_STAT = 8'h18;
  localparam logic [7:0] HR_INT_MASK = 8'h1C;

  localparam int CTRL_HBE_BIT  = 2;
  localparam logic [2:0] CMD_READ   = 3'h1;
  localparam logic [2:0] CMD_WRITE  = 3'h2;
  localparam logic [2:0] CMD_CFG_WR = 3'h3;
  localparam logic [2:0] CMD_RESET  = 3'h4;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_IRQ_BIT  = 1;

  localparam logic [5:0] HOST_SETUP_CYC  = 6'h02;
  localparam logic [5:0] HOST_STROBE_CYC = 6'h0A;
  localparam logic [5:0] HOST_RESET_CYC  = 6'h20;
endpackage

// ===== rtl/hbi_if.sv
// pin level link between the host controller and the device end
`timescale 1ns/10ps
interface hbi_if;
  import hbi_pkg::*;
  logic        reset_pin;
  logic [15:0] addr;
  logic        high_byte_enable_n;
  logic        addr_enable;
  logic        address_latch_strobe;
  logic        io_read_strobe_n;
  logic        io_write_strobe_n;
  logic [15:0] host_data_o;
  logic        host_data_oe;
  logic [15:0] dev_data_o;
  logic        dev_data_oe;
  logic [15:0] host_data_bus;
  logic [3:0]  irq_out_o;
  logic [3:0]  irq_out_oe;
  logic [3:0]  irq_out;
  logic        wide_cycle_n_oe;
  logic        wide_cycle_n;

  // weak pullups on the data bus, undriven irq lines read low
  assign host_data_bus = dev_data_oe  ? dev_data_o  :
                         host_data_oe ? host_data_o : DATA_PULLUP;
  assign irq_out       = irq_out_o & irq_out_oe;
  assign wide_cycle_n  = ~wide_cycle_n_oe;

  modport dev (
    input  reset_pin, addr, high_byte_enable_n, addr_enable,
    input  address_latch_strobe, io_read_strobe_n, io_write_strobe_n,
    input  host_data_bus,
    output dev_data_o, dev_data_oe, irq_out_o, irq_out_oe,
    output wide_cycle_n_oe
  );
  modport host (
    output reset_pin, addr, high_byte_enable_n, addr_enable,
    output address_latch_strobe, io_read_strobe_n, io_write_strobe_n,
    output host_data_o, host_data_oe,
    input  host_data_bus, irq_out, wide_cycle_n
  );
endinterface

// ===== rtl/hbi_dev_end.sv
// device end of the host bus pins: filter, latch, decode, irq routing
//
// Behaviour
// - reset counts only after 100ns high
// - local bus latches address on strobe fall
// - local irq on one of four, others off
// - processor host selects irq line zero; code drives the irq_line_select line as in local mode
// - card mode irq active low on line zero
// - local wide cycle when wide, enabled, decoded
// - card wide io when wide, enabled, selected
// - card acknowledges reads it answers
// - data bus driven only during reads
// - reads answered while read strobe low
// - processor data strobe on read pin
// - card write enable writes config registers
// - local decode only while address enable low
// - write strobe, or read-not-write on processor
`timescale 1ns/10ps
module hbi_dev_end
  import hbi_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire hbi_mode_e   bus_mode,
  input  wire logic        wide_mode,
  input  wire logic [1:0]  irq_line_select,
  input  wire logic [7:0]  base_addr_high,
  input  wire logic        int_req,
  input  wire logic [15:0] reg_rd_data,
  output logic             core_reset,
  output logic [15:0]      reg_addr,
  output logic             high_byte_sel,
  output logic             reg_rd,
  output logic             reg_wr,
  output logic [15:0]      reg_wr_data,
  output logic [7:0]       card_option_reg,
  output logic [7:0]       card_status_reg,
  hbi_if.dev               link
);
  localparam int SW = 38;

  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic          s_rst;
  logic          s_hbe_n;
  logic          s_aen;
  logic          s_ale;
  logic          s_rd_n;
  logic          s_wr_n;
  logic [15:0]   s_addr;
  logic [15:0]   s_data;
  logic [4:0]    rst_cnt_reg;
  logic [15:0]   lat_addr_reg;
  logic          lat_hbe_n_reg;
  logic          loc_sel;
  logic          card_io;
  logic          rd_cond;
  logic          wr_cond;
  logic          cfg_cond;
  logic          wide_cond;
  logic          rd_reg;
  logic          wr_d_reg;
  logic          cfg_d_reg;
  logic          wr_pulse_reg;
  logic [15:0]   wr_data_reg;
  logic [15:0]   dout_reg;
  logic [3:0]    irq_o_reg;
  logic [3:0]    irq_oe_reg;
  logic [3:0]    irq_o_next;
  logic [3:0]    irq_oe_next;
  logic          wide_oe_reg;

  function automatic logic addr_hit(input logic [15:0] a,
                                    input logic [7:0]  b);
    return a[15:4] == {b, BASE_LOW_NIBBLE};
  endfunction

  // every pin passes two flops before any logic sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {link.reset_pin, link.high_byte_enable_n,
                    link.addr_enable, link.address_latch_strobe,
                    link.io_read_strobe_n, link.io_write_strobe_n,
                    link.addr, link.host_data_bus};
      sync2_reg <= sync1_reg;
    end
  end

  assign {s_rst, s_hbe_n, s_aen, s_ale, s_rd_n, s_wr_n, s_addr, s_data}
    = sync2_reg;

  // glitch filter: a short high pulse never reaches the count limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_reg <= 5'h00;
    end else if (!s_rst) begin
      rst_cnt_reg <= 5'h00;
    end else if (rst_cnt_reg != RESET_CNT_MAX) begin
      rst_cnt_reg <= rst_cnt_reg + 5'h01;
    end
  end

  assign core_reset = (rst_cnt_reg == RESET_CNT_MAX);

  // local mode: transparent while the strobe is high, holds from its fall on; other modes always transparent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_addr_reg  <= 16'h0000;
      lat_hbe_n_reg <= 1'b1;
    end else if (bus_mode != HBI_LOCAL || s_ale) begin
      lat_addr_reg  <= s_addr;
      lat_hbe_n_reg <= s_hbe_n;
    end
  end

  assign reg_addr      = lat_addr_reg;
  assign high_byte_sel = ~lat_hbe_n_reg;

  // address enable pin: local qualifier, card select, processor strobe
  assign loc_sel = !s_aen && addr_hit(lat_addr_reg, base_addr_high);
  assign card_io = !s_aen && card_option_reg[CARD_FUNC_BIT];

  always_comb begin
    rd_cond   = 1'b0;
    wr_cond   = 1'b0;
    wide_cond = 1'b0;
    case (bus_mode)
      HBI_LOCAL: begin
        rd_cond   = loc_sel && !s_rd_n;
        wr_cond   = loc_sel && !s_wr_n;
        wide_cond = wide_mode && loc_sel;
      end
      HBI_CARD: begin
        rd_cond   = card_io && !s_rd_n;
        wr_cond   = card_io && !s_wr_n;
        wide_cond = wide_mode && card_io;
      end
      HBI_PROC: begin
        rd_cond = !s_aen && !s_rd_n && s_wr_n;
        wr_cond = !s_aen && !s_rd_n && !s_wr_n;
      end
      default: begin
        rd_cond = 1'b0;
      end
    endcase
  end

  assign cfg_cond = (bus_mode == HBI_CARD) && !s_aen && !s_ale;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_reg   <= 1'b0;
      dout_reg <= 16'h0000;
    end else begin
      rd_reg   <= rd_cond && !core_reset;
      dout_reg <= reg_rd_data;
    end
  end

  assign reg_rd           = rd_reg;
  assign link.dev_data_o  = dout_reg;
  assign link.dev_data_oe = rd_reg;

  // one write pulse per strobe, data caught at its start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_d_reg     <= 1'b0;
      wr_pulse_reg <= 1'b0;
      wr_data_reg  <= 16'h0000;
    end else begin
      wr_d_reg     <= wr_cond;
      wr_pulse_reg <= wr_cond && !wr_d_reg && !core_reset;
      if (wr_cond && !wr_d_reg) begin
        wr_data_reg <= s_data;
      end
    end
  end

  assign reg_wr      = wr_pulse_reg;
  assign reg_wr_data = wr_data_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_d_reg       <= 1'b0;
      card_option_reg <= CARD_OPT_RST;
      card_status_reg <= CARD_STAT_RST;
    end else if (core_reset) begin
      cfg_d_reg       <= 1'b0;
      card_option_reg <= CARD_OPT_RST;
      card_status_reg <= CARD_STAT_RST;
    end else begin
      cfg_d_reg <= cfg_cond;
      if (cfg_cond && !cfg_d_reg) begin
        if (lat_addr_reg == CARD_OPT_OFS) begin
          card_option_reg <= s_data[7:0];
        end
        if (lat_addr_reg == CARD_STAT_OFS) begin
          card_status_reg <= s_data[7:0];
        end
      end
    end
  end

  // card mode reuses lines zero and one for request and acknowledge
  always_comb begin
    irq_o_next  = 4'h0;
    irq_oe_next = 4'h0;
    case (bus_mode)
      HBI_CARD: begin
        irq_o_next  = {2'b00, ~rd_cond, ~int_req};
        irq_oe_next = 4'h3;
      end
      default: begin
        // processor hosts must program line zero
        irq_oe_next = 4'h1 << irq_line_select;
        irq_o_next  = int_req ? irq_oe_next : 4'h0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_o_reg   <= 4'h0;
      irq_oe_reg  <= 4'h0;
      wide_oe_reg <= 1'b0;
    end else begin
      irq_o_reg   <= irq_o_next;
      irq_oe_reg  <= irq_oe_next;
      wide_oe_reg <= wide_cond && !core_reset;
    end
  end

  assign link.irq_out_o       = irq_o_reg;
  assign link.irq_out_oe      = irq_oe_reg;
  assign link.wide_cycle_n_oe = wide_oe_reg;
endmodule

// ===== rtl/hbi_host_end.sv
// host controller end: apb registers drive one pin cycle per command
`timescale 1ns/10ps
module hbi_host_end
  import hbi_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  hbi_if.host              link
);
  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_LATCH, H_STROBE, H_HOLD, H_RESET
  } hbi_hstate_e;

  hbi_hstate_e state_reg;
  logic [2:0]  ctrl_reg;
  logic [15:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [2:0]  kind_reg;
  logic [5:0]  cnt_reg;
  logic [1:0]  stat_reg;
  logic [1:0]  mask_reg;
  logic        aen_reg;
  logic        ale_reg;
  logic        rd_n_reg;
  logic        wr_n_reg;
  logic        doe_reg;
  logic        rst_reg;
  logic [20:0] sync1_reg;
  logic [20:0] sync2_reg;
  logic [15:0] s_data;
  logic [3:0]  s_irq;
  logic        s_wide_n;
  logic        wr_acc;
  logic        cmd_go;
  logic        done_ev;
  logic        irq_lvl;
  logic        irq_lvl_d_reg;
  logic        is_local;
  logic        is_proc;

  assign pready   = 1'b1;
  assign pslverr  = 1'b0;
  assign wr_acc   = psel && penable && pwrite;
  assign cmd_go   = wr_acc && paddr == HR_CMD && state_reg == H_IDLE;
  assign is_local = ctrl_reg[1:0] == HBI_LOCAL;
  assign is_proc  = ctrl_reg[1:0] == HBI_PROC;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {link.wide_cycle_n, link.irq_out, link.host_data_bus};
      sync2_reg <= sync1_reg;
    end
  end

  assign {s_wide_n, s_irq, s_data} = sync2_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg  <= 3'h0;
      addr_reg  <= 16'h0000;
      wdata_reg <= 16'h0000;
      mask_reg  <= 2'h0;
    end else if (wr_acc) begin
      case (paddr)
        HR_CTRL:     ctrl_reg  <= pwdata[2:0];
        HR_ADDR:     addr_reg  <= pwdata[15:0];
        HR_WDATA:    wdata_reg <= pwdata[15:0];
        HR_INT_MASK: mask_reg  <= pwdata[1:0];
        default:     mask_reg  <= mask_reg;
      endcase
    end
  end

  always_comb begin
    case (paddr)
      HR_CTRL:     prdata = {29'h0, ctrl_reg};
      HR_ADDR:     prdata = {16'h0, addr_reg};
      HR_WDATA:    prdata = {16'h0, wdata_reg};
      HR_RDATA:    prdata = {16'h0, rdata_reg};
      HR_STATUS:   prdata = {26'h0, s_wide_n, s_irq,
                             state_reg != H_IDLE};
      HR_INT_STAT: prdata = {30'h0, stat_reg};
      HR_INT_MASK: prdata = {30'h0, mask_reg};
      default:     prdata = 32'h0000_0000;
    endcase
  end

  // card irq is active low on line zero, else any line high
  assign irq_lvl = (ctrl_reg[1:0] == HBI_CARD) ? !s_irq[0] : |s_irq;
  assign done_ev = (state_reg == H_HOLD) ||
                   (state_reg == H_RESET && cnt_reg == 6'h01);

  // set beats a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg      <= 2'h0;
      irq_lvl_d_reg <= 1'b0;
    end else begin
      irq_lvl_d_reg <= irq_lvl;
      stat_reg <= (stat_reg & ~((wr_acc && paddr == HR_INT_STAT) ?
                                pwdata[1:0] : 2'h0))
                | {irq_lvl && !irq_lvl_d_reg, done_ev};
    end
  end

  assign irq = |(stat_reg & mask_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= H_IDLE;
      kind_reg  <= 3'h0;
      cnt_reg   <= 6'h00;
      rdata_reg <= 16'h0000;
    end else begin
      case (state_reg)
        H_IDLE: begin
          if (cmd_go && pwdata[2:0] == CMD_RESET) begin
            state_reg <= H_RESET;
            cnt_reg   <= HOST_RESET_CYC;
          end else if (cmd_go && pwdata[2:0] >= CMD_READ &&
                       pwdata[2:0] <= CMD_CFG_WR) begin
            state_reg <= H_SETUP;
            kind_reg  <= pwdata[2:0];
            cnt_reg   <= HOST_SETUP_CYC;
          end
        end
        H_SETUP: begin
          cnt_reg <= cnt_reg - 6'h01;
          if (cnt_reg == 6'h01) begin
            state_reg <= H_LATCH;
          end
        end
        H_LATCH: begin
          state_reg <= H_STROBE;
          cnt_reg   <= HOST_STROBE_CYC;
        end
        H_STROBE: begin
          cnt_reg <= cnt_reg - 6'h01;
          if (cnt_reg == 6'h01) begin
            state_reg <= H_HOLD;
            if (kind_reg == CMD_READ) begin
              rdata_reg <= s_data;
            end
          end
        end
        H_HOLD: begin
          state_reg <= H_IDLE;
        end
        H_RESET: begin
          cnt_reg <= cnt_reg - 6'h01;
          if (cnt_reg == 6'h01) begin
            state_reg <= H_IDLE;
          end
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  // pin levels follow the state; read/write strobes only inside the strobe phase, except processor read-not-write held low from setup to hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aen_reg  <= 1'b1;
      ale_reg  <= 1'b1;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      doe_reg  <= 1'b0;
      rst_reg  <= 1'b0;
    end else begin
      rst_reg  <= state_reg == H_RESET;
      aen_reg  <= !(state_reg inside {H_SETUP, H_LATCH, H_STROBE});
      ale_reg  <= is_local ?
                  !(state_reg inside {H_LATCH, H_STROBE, H_HOLD}) :
                  !(state_reg == H_STROBE && kind_reg == CMD_CFG_WR);
      doe_reg  <= kind_reg != CMD_READ &&
                  state_reg inside {H_SETUP, H_LATCH, H_STROBE};
      if (is_proc) begin
        rd_n_reg <= state_reg != H_STROBE;
        wr_n_reg <= !(kind_reg == CMD_WRITE && state_reg != H_IDLE
                      && state_reg != H_RESET);
      end else begin
        rd_n_reg <= !(state_reg == H_STROBE && kind_reg == CMD_READ);
        wr_n_reg <= !(state_reg == H_STROBE &&
                      kind_reg == CMD_WRITE);
      end
    end
  end

  assign link.reset_pin            = rst_reg;
  assign link.addr                 = addr_reg;
  assign link.high_byte_enable_n   = !ctrl_reg[CTRL_HBE_BIT];
  assign link.addr_enable          = aen_reg;
  assign link.address_latch_strobe = ale_reg;
  assign link.io_read_strobe_n     = rd_n_reg;
  assign link.io_write_strobe_n    = wr_n_reg;
  assign link.host_data_o          = wdata_reg;
  assign link.host_data_oe         = doe_reg;
endmodule

// ===== verif/hbi_link_properties.sv
// concurrent checks on the pins between host and device ends
`timescale 1ns/10ps
module hbi_link_properties
  import hbi_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire hbi_mode_e   bus_mode,
  input wire logic        wide_mode,
  input wire logic        int_req,
  input wire logic [1:0]  irq_line_select,
  input wire logic        core_reset,
  input wire logic        reset_pin,
  input wire logic [15:0] addr,
  input wire logic        addr_enable,
  input wire logic        address_latch_strobe,
  input wire logic        io_read_strobe_n,
  input wire logic        io_write_strobe_n,
  input wire logic        host_data_oe,
  input wire logic        dev_data_oe,
  input wire logic [3:0]  irq_out,
  input wire logic [3:0]  irq_out_oe,
  input wire logic        wide_cycle_n
);
  logic [4:0] hi_cnt;

  // saturates so a long reset pulse cannot wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hi_cnt <= 5'h0;
    else if (!reset_pin)
      hi_cnt <= 5'h0;
    else if (hi_cnt != 5'h1F)
      hi_cnt <= hi_cnt + 5'h1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_card_held;
    (bus_mode == HBI_CARD) [*2];
  endsequence
  sequence s_hot_held;
    (presetn && bus_mode != HBI_CARD) [*2] ##0 $stable(irq_line_select);
  endsequence
  sequence s_no_wide;
    (bus_mode == HBI_PROC || !wide_mode) [*4];
  endsequence

  property p_reset_width;
    $rose(core_reset) |-> hi_cnt >= RESET_CNT_MAX;
  endproperty
  property p_latch;
    $fell(address_latch_strobe) && bus_mode == HBI_LOCAL
      |-> $stable(addr) && !addr_enable;
  endproperty
  property p_irq_hot;
    s_hot_held |-> irq_out_oe == (4'h1 << irq_line_select)
      && irq_out == (irq_out_oe & {4{$past(int_req)}});
  endproperty
  property p_irq_card;
    s_card_held |-> irq_out_oe == 4'h3 && irq_out[0] == !$past(int_req);
  endproperty
  property p_bus_owner;
    !(dev_data_oe && host_data_oe);
  endproperty
  property p_read_cause;
    dev_data_oe |-> !$past(io_read_strobe_n, 3) && !$past(addr_enable, 3);
  endproperty
  property p_read_end;
    $rose(io_read_strobe_n) |-> ##[1:4] !dev_data_oe;
  endproperty
  property p_wide_cause;
    !wide_cycle_n |-> !$past(addr_enable, 3);
  endproperty
  property p_no_wide;
    s_no_wide |-> wide_cycle_n;
  endproperty
  property p_strobes;
    bus_mode != HBI_PROC |-> io_read_strobe_n || io_write_strobe_n;
  endproperty

  a_reset_width: assert property (p_reset_width)
    else $error("short reset passed");
  a_latch: assert property (p_latch)
    else $error("latch addr moved");
  a_irq_hot: assert property (p_irq_hot)
    else $error("wrong irq line or level");
  a_irq_card: assert property (p_irq_card)
    else $error("card irq request wrong");
  a_bus_owner: assert property (p_bus_owner)
    else $error("bus fight");
  a_read_cause: assert property (p_read_cause)
    else $error("drive without read");
  a_read_end: assert property (p_read_end)
    else $error("drive after read");
  a_wide_cause: assert property (p_wide_cause)
    else $error("wide without enable");
  a_no_wide: assert property (p_no_wide)
    else $error("wide not allowed");
  a_strobes: assert property (p_strobes)
    else $error("both strobes low");
endmodule

// ===== verif/test_host_bus_interface_pins.sv
// self-checking bench joining host and device ends
`timescale 1ns/10ps
`define CHK(n, e, g) check_val(n, 32'(e), 32'(g))
module test_host_bus_interface_pins;
  import hbi_pkg::*;
  localparam logic [15:0] KEY = 16'hA5C3;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr, base_addr_high, card_option_reg, card_status_reg;
  logic [31:0] pwdata, prdata;
  hbi_mode_e   bus_mode;
  logic        wide_mode, int_req, core_reset, high_byte_sel, reg_rd, reg_wr;
  logic [1:0]  irq_line_select;
  logic [15:0] reg_rd_data, reg_addr, reg_wr_data, wr_data_seen, wr_addr_seen;
  int          fails = 0, samples_checked = 0;
  int          wr_cnt = 0, wide_cyc = 0, ack_cyc = 0, rst_cyc = 0, rd_cyc = 0;

  hbi_if link_if();
  // register file stand-in, stable per address
  assign reg_rd_data = reg_addr ^ KEY;

  hbi_host_end i_hbi_host_end (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .link(link_if));
  hbi_dev_end i_hbi_dev_end (.pclk, .presetn, .bus_mode, .wide_mode,
    .int_req, .irq_line_select, .base_addr_high, .reg_rd_data, .core_reset,
    .reg_rd, .reg_addr, .high_byte_sel, .reg_wr, .reg_wr_data,
    .card_option_reg, .card_status_reg, .link(link_if));
  hbi_link_properties i_hbi_link_properties (.pclk, .presetn, .bus_mode,
    .wide_mode, .int_req, .irq_line_select, .core_reset,
    .reset_pin(link_if.reset_pin),
    .addr(link_if.addr), .addr_enable(link_if.addr_enable),
    .address_latch_strobe(link_if.address_latch_strobe),
    .io_read_strobe_n(link_if.io_read_strobe_n),
    .io_write_strobe_n(link_if.io_write_strobe_n),
    .host_data_oe(link_if.host_data_oe), .dev_data_oe(link_if.dev_data_oe),
    .irq_out(link_if.irq_out), .irq_out_oe(link_if.irq_out_oe),
    .wide_cycle_n(link_if.wide_cycle_n));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (reg_rd === 1'b1)
      rd_cyc++;
    if (reg_wr === 1'b1) begin
      wr_cnt++;
      wr_data_seen = reg_wr_data;
      wr_addr_seen = reg_addr;
    end
    if (link_if.wide_cycle_n === 1'b0)
      wide_cyc++;
    if (bus_mode == HBI_CARD && link_if.irq_out[1] === 1'b0)
      ack_cyc++;
    if (core_reset === 1'b1)
      rst_cyc++;
  end

  task check_val(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic apb_xfer(input logic w, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] q);
    logic r, e;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed, the watchdog ends a hang
    do begin
      @(negedge pclk);
      {r, e, q} = {pready, pslverr, prdata};
      @(posedge pclk);
    end while (r !== 1'b1);
    `CHK("apb_err", 1'b0, e);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb_xfer(1'b1, a, d, q);
  endtask

  task automatic apb_rd(input logic [7:0] a, output logic [31:0] q);
    apb_xfer(1'b0, a, 32'h0000_0000, q);
  endtask

  task automatic set_mode(input hbi_mode_e m);
    @(posedge pclk);
    bus_mode <= m;
    apb_wr(HR_CTRL, {29'h0, 1'b1, m});
  endtask

  task automatic link_op(input logic [2:0] c, input logic [15:0] a,
                         input logic [15:0] d, output logic [31:0] q);
    int n;
    apb_wr(HR_ADDR, {16'h0000, a});
    apb_wr(HR_WDATA, {16'h0000, d});
    apb_wr(HR_CMD, {29'h0, c});
    n = 0;
    q = 32'h0000_0001;
    while (q[0] !== 1'b0 && n < 200) begin
      apb_rd(HR_STATUS, q);
      n++;
    end
    apb_rd(HR_INT_STAT, q);
    `CHK("cycle_done", 1'b1, q[INT_DONE_BIT]);
    apb_wr(HR_INT_STAT, 32'h1 << INT_DONE_BIT);
    apb_rd(HR_RDATA, q);
  endtask

  task automatic t_local();
    logic [31:0] rd;
    int          w0, c0;
    set_mode(HBI_LOCAL);
    w0 = wr_cnt;
    c0 = wide_cyc;
    link_op(CMD_WRITE, 16'h3C0A, 16'h1234, rd);
    `CHK("local_wr_count", w0 + 1, wr_cnt);
    `CHK("local_wr_data", 16'h1234, wr_data_seen);
    `CHK("local_wr_addr", 16'h3C0A, wr_addr_seen);
    `CHK("local_hbe", 1'b1, high_byte_sel);
    `CHK("local_wide", 1'b1, wide_cyc > c0);
    link_op(CMD_READ, 16'h3C0A, 16'h0000, rd);
    `CHK("local_rd", 16'h3C0A ^ KEY, rd[15:0]);
    `CHK("local_reg_rd", 1'b1, rd_cyc > 0);
    w0 = wr_cnt;
    c0 = wide_cyc;
    // one step past the decoded block, a4 set
    link_op(CMD_WRITE, 16'h3C1A, 16'h5678, rd);
    link_op(CMD_READ, 16'h3C1A, 16'h0000, rd);
    `CHK("foreign_wr", w0, wr_cnt);
    `CHK("foreign_wide", c0, wide_cyc);
    `CHK("foreign_rd", DATA_PULLUP, rd[15:0]);
  endtask

  task automatic t_irq();
    logic [31:0] rd;
    for (int s = 0; s < 4; s++) begin
      @(posedge pclk);
      irq_line_select <= 2'(s);
      int_req <= 1'b1;
      repeat (4) @(posedge pclk);
      `CHK("irq_line", 4'h1 << s, link_if.irq_out);
      int_req <= 1'b0;
      repeat (4) @(posedge pclk);
      `CHK("irq_idle", 4'h0, link_if.irq_out);
    end
    apb_rd(HR_INT_STAT, rd);
    `CHK("irq_event", 1'b1, rd[INT_IRQ_BIT]);
    apb_wr(HR_INT_MASK, 32'h1 << INT_IRQ_BIT);
    repeat (2) @(posedge pclk);
    `CHK("irq_unmasked", 1'b1, irq);
    apb_wr(HR_INT_MASK, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    `CHK("irq_masked", 1'b0, irq);
    apb_wr(HR_INT_STAT, 32'h1 << INT_IRQ_BIT);
    apb_rd(HR_INT_STAT, rd);
    `CHK("irq_cleared", 1'b0, rd[INT_IRQ_BIT]);
    apb_wr(8'h20, 32'hFFFF_FFFF);
    apb_rd(8'h20, rd);
    `CHK("unmapped", 32'h0000_0000, rd);
    set_mode(HBI_PROC);
    irq_line_select <= 2'h0;
    int_req <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK("proc_irq", 4'h1, link_if.irq_out);
    int_req <= 1'b0;
  endtask

  task automatic t_proc();
    logic [31:0] rd;
    int          w0, c0;
    w0 = wr_cnt;
    c0 = wide_cyc;
    link_op(CMD_WRITE, 16'h0100, 16'hBEEF, rd);
    `CHK("proc_wr_count", w0 + 1, wr_cnt);
    `CHK("proc_wr_data", 16'hBEEF, wr_data_seen);
    link_op(CMD_READ, 16'h0100, 16'h0000, rd);
    `CHK("proc_rd", 16'h0100 ^ KEY, rd[15:0]);
    `CHK("proc_wide", c0, wide_cyc);
  endtask

  task automatic t_card();
    logic [31:0] rd;
    int          a0, c0;
    set_mode(HBI_CARD);
    a0 = ack_cyc;
    c0 = wide_cyc;
    link_op(CMD_READ, 16'h0008, 16'h0000, rd);
    `CHK("card_off_rd", DATA_PULLUP, rd[15:0]);
    `CHK("card_off_ack", a0, ack_cyc);
    `CHK("card_off_wide", c0, wide_cyc);
    link_op(CMD_CFG_WR, CARD_OPT_OFS, 16'h0001, rd);
    `CHK("card_opt", 8'h01, card_option_reg);
    link_op(CMD_CFG_WR, CARD_STAT_OFS, 16'h005A, rd);
    `CHK("card_stat", 8'h5A, card_status_reg);
    link_op(CMD_READ, 16'h0008, 16'h0000, rd);
    `CHK("card_rd", 16'h0008 ^ KEY, rd[15:0]);
    `CHK("card_ack", 1'b1, ack_cyc > a0);
    `CHK("card_wide", 1'b1, wide_cyc > c0);
    int_req <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK("card_irq_on", 1'b0, link_if.irq_out[0]);
    int_req <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK("card_irq_off", 1'b1, link_if.irq_out[0]);
  endtask

  task automatic t_reset();
    logic [31:0] rd;
    int          r0, d;
    r0 = rst_cyc;
    link_op(CMD_RESET, 16'h0000, 16'h0000, rd);
    repeat (8) @(posedge pclk);
    d = rst_cyc - r0;
    // only the tail of the pin pulse may reach the core
    `CHK("reset_span", 1'b1,
         d > 0 && d <= int'(HOST_RESET_CYC) - RESET_MIN_CYC + 4);
    `CHK("reset_clears", CARD_OPT_RST, card_option_reg);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, int_req,
     irq_line_select} = '0;
    bus_mode = HBI_LOCAL;
    wide_mode = 1'b1;
    base_addr_high = 8'h3C;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_local();
    t_irq();
    t_proc();
    t_card();
    t_reset();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    give_verdict();
  end
endmodule
